// ---- hw/pfac_pkg.sv ----
// Constants for the port function and address command interpreter
package pfac_pkg;

  localparam int          ADDR_W       = 18;
  localparam int          WORD_W       = 16;
  localparam int          STA_W        = 48;
  localparam logic [1:0]  CB_LAST      = 2'h3;
  localparam logic [1:0]  CB_FIRST_OUT = 2'h1;
  localparam int          GRP_DEPTH    = 10;
  localparam logic [7:0]  GRP_MAX      = 8'h0A;
  localparam logic [1:0]  ENTRY_LAST   = 2'h2;

  localparam logic [7:0]  FC_NOP       = 8'h00;
  localparam logic [7:0]  FC_USTART    = 8'h01;
  localparam logic [7:0]  FC_RD_FACT   = 8'h02;
  localparam logic [7:0]  FC_NOP_ALT   = 8'h03;
  localparam logic [7:0]  FC_RD_STA    = 8'h04;
  localparam logic [7:0]  FC_WR_STA    = 8'h05;
  localparam logic [7:0]  FC_RD_GRP    = 8'h06;
  localparam logic [7:0]  FC_WR_GRP    = 8'h07;
  localparam logic [7:0]  FC_FIRST_EXT = 8'h08;
  localparam logic [7:0]  FC_STAT_CLR  = 8'h0F;
  localparam logic [7:0]  FC_MAINT_LO  = 8'h10;
  localparam logic [7:0]  FC_MAINT_HI  = 8'h15;

  localparam int          FC_HI_MSB    = 15;
  localparam int          FC_HI_LSB    = 8;
  localparam int          LEN_MSB      = 15;
  localparam int          LEN_LSB      = 8;
  localparam int          W2_RSV_MSB   = 7;
  localparam int          W2_RSV_LSB   = 2;

  typedef enum logic [2:0] {
    PFAC_IDLE     = 3'b000,
    PFAC_FETCH    = 3'b001,
    PFAC_DECODE   = 3'b010,
    PFAC_WRITE_CB = 3'b011,
    PFAC_GRP_LOAD = 3'b100,
    PFAC_GRP_DUMP = 3'b101,
    PFAC_OUTSIDE  = 3'b110,
    PFAC_FINISH   = 3'b111
  } pfac_state_e;

endpackage

// ---- hw/pfac_interp.sv ----
// Port function interpreter: control block fetch, address and group table commands
`timescale 1ns/100ps
module pfac_interp
  import pfac_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               cmd_start,
  input  wire logic [ADDR_W-1:0]  control_block_base,
  input  wire logic               port_running,
  input  wire logic [STA_W-1:0]   factory_station_address,
  input  wire logic               mem_ack,
  input  wire logic [WORD_W-1:0]  mem_rdata,
  input  wire logic               outside_ack,
  input  wire logic               outside_error,
  input  wire logic [3:0]         group_index,
  output logic                    mem_req,
  output logic                    mem_we,
  output logic [ADDR_W-1:0]       mem_addr,
  output logic [WORD_W-1:0]       mem_wdata,
  output logic                    outside_req,
  output logic [7:0]              outside_code,
  output logic                    outside_maint,
  output logic                    outside_status_clear,
  output logic                    microcode_start,
  output logic [14:0]             internal_block_word_address,
  output logic [STA_W-1:0]        active_station_address,
  output logic                    group_compare_enable,
  output logic [3:0]              group_count,
  output logic [STA_W-1:0]        group_entry,
  output logic                    busy,
  output logic                    command_done_flag,
  output logic                    command_error_flag
);

  pfac_state_e        state_reg;
  logic [1:0]         idx_reg;
  logic [WORD_W-1:0]  cb_reg [0:3];
  logic [3:0]         ent_reg;
  logic [1:0]         part_reg;
  logic [4:0]         dw_reg;
  logic               err_reg;
  logic               sta_written_reg;
  logic               grp_written_reg;
  logic [STA_W-1:0]   grp_tab [0:GRP_DEPTH-1];

  // Decode of the fetched control block
  wire logic [7:0]        fc       = cb_reg[0][7:0];
  wire logic [7:0]        grp_len  = cb_reg[2][LEN_MSB:LEN_LSB];
  wire logic              hi_bad   = cb_reg[0][FC_HI_MSB:FC_HI_LSB] != 8'h00;
  wire logic              w1_bit0  = cb_reg[1][0];
  wire logic              is_grp   = (fc == FC_RD_GRP) || (fc == FC_WR_GRP);
  wire logic              grp_bad  = w1_bit0 || (cb_reg[2][W2_RSV_MSB:W2_RSV_LSB] != 6'h00)
                                     || (grp_len > GRP_MAX);
  wire logic              ext_fc   = (fc >= FC_FIRST_EXT) && (fc <= FC_MAINT_HI);
  wire logic              decode_err = hi_bad
                                     || ((fc == FC_USTART) && (w1_bit0 || port_running))
                                     || ((fc == FC_WR_STA) && w1_bit0)
                                     || (is_grp && grp_bad)
                                     || (fc > FC_MAINT_HI);
  wire logic [ADDR_W-1:0] host_data_block_base     = {cb_reg[2][1:0], cb_reg[1][15:1], 1'b0};
  wire logic [3:0]        dump_n   = (grp_len < {4'h0, group_count}) ? grp_len[3:0]
                                                                     : group_count;
  wire logic [3:0]        xfer_n   = (state_reg == PFAC_GRP_LOAD) ? grp_len[3:0] : dump_n;
  wire logic [STA_W-1:0]  ret_addr = ((fc == FC_RD_FACT) || !sta_written_reg)
                                     ? factory_station_address : active_station_address;
  wire logic [ADDR_W-1:0] cb_addr  = control_block_base + {15'h0000, idx_reg, 1'b0};
  wire logic [ADDR_W-1:0] data_addr = host_data_block_base + {12'h000, dw_reg, 1'b0};
  wire logic              mem_state = (state_reg == PFAC_FETCH) || (state_reg == PFAC_WRITE_CB)
                                     || (state_reg == PFAC_GRP_LOAD)
                                     || (state_reg == PFAC_GRP_DUMP);
  wire logic              issue    = mem_state && !mem_req;
  wire logic              beat     = mem_req && mem_ack;
  wire logic              last_ent = (ent_reg == xfer_n - 4'h1) && (part_reg == ENTRY_LAST);
  wire logic [STA_W-1:0]  grp_word = grp_tab[ent_reg];

  function automatic logic [WORD_W-1:0] sta_word(input logic [STA_W-1:0] a,
                                                 input logic [1:0] i);
    logic [WORD_W-1:0] w;
    w = {a[15:1], 1'b0};
    if (i == 2'h2) begin
      w = a[31:16];
    end else if (i == 2'h3) begin
      w = a[47:32];
    end
    return w;
  endfunction

  // Group entries go back exactly as stored, their set low bit included
  wire logic [WORD_W-1:0] out_word = (state_reg == PFAC_WRITE_CB)
                                     ? sta_word(ret_addr, idx_reg)
                                     : grp_word[part_reg * 16 +: 16];

  // Sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= PFAC_IDLE;
      idx_reg   <= 2'h0;
      ent_reg   <= 4'h0;
      part_reg  <= 2'h0;
      dw_reg    <= 5'h00;
      err_reg   <= 1'b0;
    end else begin
      unique case (state_reg)
        PFAC_IDLE: begin
          if (cmd_start) begin
            state_reg <= PFAC_FETCH;
            idx_reg   <= 2'h0;
            err_reg   <= 1'b0;
          end
        end
        PFAC_FETCH: begin
          if (beat) begin
            idx_reg <= idx_reg + 2'h1;
            if (idx_reg == CB_LAST) begin
              state_reg <= PFAC_DECODE;
            end
          end
        end
        PFAC_DECODE: begin
          ent_reg   <= 4'h0;
          part_reg  <= 2'h0;
          dw_reg    <= 5'h00;
          idx_reg   <= CB_FIRST_OUT;
          state_reg <= PFAC_FINISH;
          if (decode_err) begin
            err_reg <= 1'b1;
          end else if ((fc == FC_RD_FACT) || (fc == FC_RD_STA)) begin
            state_reg <= PFAC_WRITE_CB;
          end else if ((fc == FC_RD_GRP) && grp_written_reg && (dump_n != 4'h0)) begin
            state_reg <= PFAC_GRP_DUMP;
          end else if ((fc == FC_WR_GRP) && (grp_len != 8'h00)) begin
            state_reg <= PFAC_GRP_LOAD;
          end else if (ext_fc) begin
            state_reg <= PFAC_OUTSIDE;
          end
        end
        PFAC_WRITE_CB: begin
          if (beat) begin
            idx_reg <= idx_reg + 2'h1;
            if (idx_reg == CB_LAST) begin
              state_reg <= PFAC_FINISH;
            end
          end
        end
        PFAC_GRP_LOAD, PFAC_GRP_DUMP: begin
          if (beat) begin
            dw_reg <= dw_reg + 5'h01;
            if (part_reg == ENTRY_LAST) begin
              part_reg <= 2'h0;
              ent_reg  <= ent_reg + 4'h1;
            end else begin
              part_reg <= part_reg + 2'h1;
            end
            if (last_ent) begin
              state_reg <= PFAC_FINISH;
            end
          end
        end
        PFAC_OUTSIDE: begin
          if (outside_ack) begin
            err_reg   <= outside_error;
            state_reg <= PFAC_FINISH;
          end
        end
        PFAC_FINISH: begin
          state_reg <= PFAC_IDLE;
        end
      endcase
    end
  end

  // Host memory master: one word at a time, request held until acknowledged
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
    end else if (beat) begin
      mem_req <= 1'b0;
      mem_we  <= 1'b0;
    end else if (issue) begin
      mem_req   <= 1'b1;
      mem_we    <= (state_reg == PFAC_WRITE_CB) || (state_reg == PFAC_GRP_DUMP);
      mem_addr  <= ((state_reg == PFAC_FETCH) || (state_reg == PFAC_WRITE_CB))
                   ? cb_addr : data_addr;
      mem_wdata <= out_word;
    end
  end

  // Control words; word one is never written back, so its code byte stays intact
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cb_reg[0] <= '0;
      cb_reg[1] <= '0;
      cb_reg[2] <= '0;
      cb_reg[3] <= '0;
    end else if ((state_reg == PFAC_FETCH) && beat) begin
      cb_reg[idx_reg] <= mem_rdata;
    end
  end

  // Stored station address and group table state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active_station_address <= '0;
      sta_written_reg        <= 1'b0;
      grp_written_reg        <= 1'b0;
      group_compare_enable   <= 1'b0;
      group_count            <= 4'h0;
    end else begin
      if ((state_reg == PFAC_DECODE) && !decode_err && (fc == FC_WR_STA)) begin
        active_station_address <= {cb_reg[3], cb_reg[2], cb_reg[1]};
        sta_written_reg        <= 1'b1;
      end
      if ((state_reg == PFAC_DECODE) && !decode_err && (fc == FC_WR_GRP)) begin
        group_compare_enable <= 1'b0;
        group_count          <= grp_len[3:0];
      end
      if (((state_reg == PFAC_GRP_LOAD) && beat && last_ent)
          || ((state_reg == PFAC_DECODE) && !decode_err && (fc == FC_WR_GRP)
              && (grp_len == 8'h00))) begin
        group_compare_enable <= 1'b1;
        grp_written_reg      <= 1'b1;
      end
    end
  end

  // Group table storage
  always_ff @(posedge clk) begin
    if ((state_reg == PFAC_GRP_LOAD) && beat) begin
      grp_tab[ent_reg][part_reg * 16 +: 16] <= mem_rdata;
    end
  end

  // Outputs toward microcode engine, outside function handlers and status
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      microcode_start             <= 1'b0;
      internal_block_word_address <= '0;
      outside_req                 <= 1'b0;
      outside_code                <= 8'h00;
      outside_maint               <= 1'b0;
      outside_status_clear        <= 1'b0;
      group_entry                 <= '0;
      busy                        <= 1'b0;
      command_done_flag           <= 1'b0;
      command_error_flag          <= 1'b0;
    end else begin
      microcode_start <= (state_reg == PFAC_DECODE) && !decode_err && (fc == FC_USTART);
      if ((state_reg == PFAC_DECODE) && !decode_err && (fc == FC_USTART)) begin
        internal_block_word_address <= cb_reg[1][15:1];
      end
      if ((state_reg == PFAC_DECODE) && !decode_err && ext_fc) begin
        outside_req          <= 1'b1;
        outside_code         <= fc;
        outside_maint        <= (fc >= FC_MAINT_LO);
        outside_status_clear <= (fc == FC_STAT_CLR);
      end else if (outside_ack) begin
        outside_req          <= 1'b0;
        outside_maint        <= 1'b0;
        outside_status_clear <= 1'b0;
      end
      group_entry <= (group_index < GRP_DEPTH[3:0]) ? grp_tab[group_index] : '0;
      busy        <= (state_reg != PFAC_IDLE) ? (state_reg != PFAC_FINISH) : cmd_start;
      // Codes 0 and 3 fall through decode straight to a plain done
      command_done_flag  <= (state_reg == PFAC_FINISH) && !err_reg;
      command_error_flag <= (state_reg == PFAC_FINISH) && err_reg;
    end
  end

  default clocking cb_clk @(posedge clk); endclocking
  default disable iff (reset);

  wire logic dec_ok = (state_reg == PFAC_DECODE) && !decode_err;

  a_done_error_excl: assert property (!(command_done_flag && command_error_flag))
    else $error("done and error flags raised together");
  a_upper_byte_err: assert property ((state_reg == PFAC_DECODE) && hi_bad
      |=> (state_reg == PFAC_FINISH) ##1 command_error_flag)
    else $error("nonzero upper byte not reported as error");
  a_ustart_checks: assert property (microcode_start
      |-> !$past(w1_bit0) && !$past(port_running) && $past(fc) == FC_USTART)
    else $error("microcode start despite failed checks");
  a_ustart_addr: assert property (microcode_start
      |-> internal_block_word_address == cb_reg[1][15:1] ##1 command_done_flag)
    else $error("microcode start address or completion wrong");
  a_sta_bit0_reject: assert property ((state_reg == PFAC_DECODE) && fc == FC_WR_STA && w1_bit0
      |=> $stable(active_station_address) ##1 command_error_flag)
    else $error("odd station address accepted");
  a_sta_replace: assert property (dec_ok && fc == FC_WR_STA
      |=> active_station_address == {$past(cb_reg[3]), $past(cb_reg[2]), $past(cb_reg[1])})
    else $error("station address not fully replaced");
  a_default_return: assert property ((state_reg == PFAC_WRITE_CB) && mem_req && idx_reg == 2'h1
      && fc == FC_RD_STA && !sta_written_reg
      |-> mem_wdata == {factory_station_address[15:1], 1'b0})
    else $error("unwritten station read did not return factory address");
  a_group_limit: assert property (group_count <= GRP_MAX[3:0])
    else $error("group table count above ten");
  a_group_untouched: assert property (dec_ok && fc == FC_RD_GRP && !grp_written_reg
      |=> (state_reg == PFAC_FINISH) && !mem_req ##1 command_done_flag)
    else $error("unwritten group table touched host block");
  a_host_write_src: assert property (mem_req && mem_we
      |-> (state_reg == PFAC_WRITE_CB) || (state_reg == PFAC_GRP_DUMP))
    else $error("host write outside a read-type function");
  a_fetch_addr: assert property ((state_reg == PFAC_FETCH) && mem_req
      |-> mem_addr == cb_addr && !mem_we)
    else $error("control block fetched from wrong address");
  a_group_enable: assert property (command_done_flag && fc == FC_WR_GRP
      |-> group_compare_enable && group_count == grp_len[3:0])
    else $error("group load completed without enabling comparison");

  c_station_write: cover property (dec_ok && fc == FC_WR_STA);
  c_group_dump: cover property ((state_reg == PFAC_GRP_DUMP) && beat && last_ent);
  c_ustart: cover property (microcode_start);
  c_outside_maint: cover property (outside_req && outside_maint);

endmodule

// ---- tb/pfac_host_mem.sv ----
// Host memory model answering the interpreter's word transfers
`timescale 1ns/100ps
module pfac_host_mem
  import pfac_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              mem_req,
  input  wire logic              mem_we,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [WORD_W-1:0] mem_wdata,
  input  wire logic [1:0]        lat,
  output logic                   mem_ack,
  output logic [WORD_W-1:0]      mem_rdata
);
  logic [WORD_W-1:0] mem [0:255];
  logic [1:0]        wait_reg;

  initial begin
    mem_ack   = 1'b0;
    mem_rdata = 16'h0000;
    wait_reg  = 2'h0;
  end

  always @(posedge clk) begin
    // Read data is only valid with the acknowledge; otherwise it keeps changing
    mem_rdata <= ~mem_rdata;
    if (mem_ack) begin
      mem_ack  <= 1'b0;
      wait_reg <= 2'h0;
    end else if (mem_req && wait_reg == lat) begin
      mem_ack <= 1'b1;
      if (mem_we) begin
        mem[mem_addr[8:1]] <= mem_wdata;
      end else begin
        mem_rdata <= mem[mem_addr[8:1]];
      end
    end else if (mem_req) begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Self-checking testbench for the port function interpreter
`timescale 1ns/100ps
module testbench;
  import pfac_pkg::*;
  localparam logic [STA_W-1:0] FACT = 48'h1234_5678_9ABD;
  localparam logic [STA_W-1:0] E0   = 48'hA1A2_B3B4_C5C7;
  localparam logic [STA_W-1:0] E1   = 48'h1112_1314_1517;
  logic clk, reset, cmd_start, port_running, outside_ack, outside_error;
  logic [3:0] group_index;
  logic [1:0] lat;
  logic mem_req, mem_we, mem_ack, outside_req, outside_maint, outside_status_clear;
  logic microcode_start, group_compare_enable, busy, command_done_flag, command_error_flag;
  logic [ADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_wdata, mem_rdata;
  logic [7:0] outside_code, got_code, cbw;
  logic [14:0] internal_block_word_address;
  logic [STA_W-1:0] active_station_address, group_entry;
  logic [3:0] group_count;
  logic got_done, got_err, got_us, got_sc, got_mt;
  int n_mismatch, tests_run;

  pfac_interp dut (.clk(clk), .reset(reset), .cmd_start(cmd_start),
    .control_block_base({9'h000, cbw, 1'b0}), .port_running(port_running),
    .factory_station_address(FACT), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .outside_ack(outside_ack), .outside_error(outside_error), .group_index(group_index),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .outside_req(outside_req), .outside_code(outside_code), .outside_maint(outside_maint),
    .outside_status_clear(outside_status_clear), .microcode_start(microcode_start),
    .internal_block_word_address(internal_block_word_address),
    .active_station_address(active_station_address),
    .group_compare_enable(group_compare_enable), .group_count(group_count),
    .group_entry(group_entry), .busy(busy), .command_done_flag(command_done_flag),
    .command_error_flag(command_error_flag));
  pfac_host_mem host (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  // Places one control block, starts it and serves the outside handler
  task run_cmd(input logic [15:0] w0, w1, w2, w3, input logic oerr);
    int i;
    host.mem[cbw] = w0;
    host.mem[cbw + 8'h01] = w1;
    host.mem[cbw + 8'h02] = w2;
    host.mem[cbw + 8'h03] = w3;
    {got_done, got_err, got_us, got_sc, got_mt, got_code} = '0;
    @(negedge clk) cmd_start = 1'b1;
    @(negedge clk) cmd_start = 1'b0;
    chk(busy === 1'b1, "busy not raised");
    for (i = 0; i < 400 && !(got_done || got_err); i++) begin
      @(negedge clk);
      if (command_done_flag === 1'b1) got_done = 1'b1;
      if (command_error_flag === 1'b1) got_err = 1'b1;
      if (microcode_start === 1'b1) got_us = 1'b1;
      outside_ack = (outside_req === 1'b1) && (got_code == 8'h00);
      if (outside_ack) begin
        outside_error = oerr;
        got_code = outside_code;
        got_sc = outside_status_clear;
        got_mt = outside_maint;
      end
    end
    chk((got_done ^ got_err) === 1'b1, "no single completion");
    chk(busy === 1'b0, "busy after completion");
  endtask

  task chk_sta(input logic [STA_W-1:0] a);
    chk(host.mem[cbw + 8'h01] === {a[15:1], 1'b0}, "address word 2");
    chk(host.mem[cbw + 8'h02] === a[31:16], "address word 3");
    chk(host.mem[cbw + 8'h03] === a[47:32], "address word 4");
  endtask

  task t_nop();
    run_cmd(16'h0000, 16'hA5A5, 16'h5A5A, 16'h0F0F, 1'b0);
    chk(got_done === 1'b1, "no-op not done");
    run_cmd(16'h0003, 16'hA5A5, 16'h5A5A, 16'h0F0F, 1'b0);
    chk(got_done && host.mem[8'h81] === 16'hA5A5, "code 3 acted");
    run_cmd(16'h0104, 16'hA5A5, 16'h0, 16'h0, 1'b0);
    chk(got_err && host.mem[8'h80] === 16'h0104, "upper byte");
    chk(host.mem[8'h81] === 16'hA5A5, "rejected read wrote");
    run_cmd(16'h0016, 16'h0, 16'h0, 16'h0, 1'b0);
    chk(got_err === 1'b1, "code above maintenance range");
  endtask

  task t_station();
    run_cmd(16'h0004, 16'h0, 16'h0, 16'h0, 1'b0);
    chk_sta(FACT);
    run_cmd(16'h0002, 16'h0, 16'h0, 16'h0, 1'b0);
    chk_sta(FACT);
    run_cmd(16'h0005, 16'h4422, 16'h6655, 16'h8877, 1'b0);
    chk(active_station_address === 48'h8877_6655_4422, "station write");
    run_cmd(16'h0005, 16'h0001, 16'hFFFF, 16'hFFFF, 1'b0);
    chk(got_err === 1'b1, "odd station address");
    chk(active_station_address === 48'h8877_6655_4422, "rejected write");
    run_cmd(16'h0005, 16'h0010, 16'h0000, 16'h0020, 1'b0);
    run_cmd(16'h0004, 16'h0, 16'h0, 16'h0, 1'b0);
    chk_sta(48'h0020_0000_0010);
    @(negedge clk) cbw = 8'hC0;
    run_cmd(16'h0004, 16'h0, 16'h0, 16'h0, 1'b0);
    chk_sta(48'h0020_0000_0010);
    cbw = 8'h80;
  endtask

  task t_ustart();
    run_cmd(16'h000F, 16'h0, 16'h0, 16'h0, 1'b0);
    chk(got_sc === 1'b1 && got_code === 8'h0F && got_done, "status clear");
    run_cmd(16'h0011, 16'h0, 16'h0, 16'h0, 1'b0);
    chk(got_mt === 1'b1 && got_code === 8'h11, "maintenance load");
    run_cmd(16'h0010, 16'h0, 16'h0, 16'h0, 1'b1);
    chk(got_mt === 1'b1 && got_err === 1'b1, "maintenance error");
    run_cmd(16'h0001, 16'h0246, 16'h0, 16'h0, 1'b0);
    chk(got_us && internal_block_word_address === 15'h0123, "start");
    run_cmd(16'h0001, 16'h0247, 16'h0, 16'h0, 1'b0);
    chk(got_err && !got_us, "odd microaddress");
    port_running = 1'b1;
    run_cmd(16'h0001, 16'h0246, 16'h0, 16'h0, 1'b0);
    chk(got_err && !got_us, "start while running");
    port_running = 1'b0;
  endtask

  task t_group();
    lat = 2'h2;
    host.mem[8'h20] = 16'hDEAD;
    run_cmd(16'h0006, 16'h0040, 16'h0200, 16'h0, 1'b0);
    chk(got_done && host.mem[8'h20] === 16'hDEAD, "empty table read");
    {host.mem[8'h22], host.mem[8'h21], host.mem[8'h20]} = E0;
    {host.mem[8'h25], host.mem[8'h24], host.mem[8'h23]} = E1;
    run_cmd(16'h0007, 16'h0040, 16'h0200, 16'h0, 1'b0);
    chk(group_compare_enable === 1'b1 && group_count === 4'h2, "load");
    @(negedge clk) group_index = 4'h1;
    repeat (2) @(negedge clk);
    chk(group_entry === E1, "stored entry");
    for (int k = 8'h20; k < 8'h26; k++) host.mem[k] = 16'h0000;
    run_cmd(16'h0006, 16'h0040, 16'h0100, 16'h0, 1'b0);
    chk(host.mem[8'h22] === E0[47:32] && host.mem[8'h21] === E0[31:16], "read");
    chk(host.mem[8'h20] === E0[15:0], "entry low word");
    chk(host.mem[8'h24] === 16'h0000, "truncated read");
    run_cmd(16'h0007, 16'h0040, 16'h0B00, 16'h0, 1'b0);
    chk(got_err && group_count === 4'h2, "eleven entries");
    run_cmd(16'h0007, 16'h0041, 16'h0100, 16'h0, 1'b0);
    chk(got_err && group_count === 4'h2, "odd data block base");
    run_cmd(16'h0006, 16'h0040, 16'h0104, 16'h0, 1'b0);
    chk(got_err && host.mem[8'h20] === E0[15:0], "reserved length bits");
    lat = 2'h0;
  endtask

  initial begin
    reset = 1'b1;
    {cmd_start, port_running, outside_ack, outside_error} = '0;
    group_index = 4'h0;
    lat = 2'h0;
    cbw = 8'h80;
    n_mismatch = 0;
    tests_run = 0;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    t_nop();
    t_station();
    t_ustart();
    t_group();
    test_done();
  end

  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end
endmodule
